/* File: hw/mist_filter.sv */
// per-channel debounce filter for field inputs
// input is already synchronised to mclk_i
`timescale 1ns/100ps
`include "mist_params.svh"
module mist_filter #(
  parameter int FILT_LEN = `MIST_FILT_LEN
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic sample_i,
  input wire logic hold_i,
  output logic state_o
);
  logic [$clog2(FILT_LEN+1)-1:0] cnt_q;
  logic state_q;
  assign state_o = state_q;
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
      state_q <= 1'b0;
    end else if (hold_i) begin
      cnt_q <= '0;
    end else if (sample_i == state_q) begin
      cnt_q <= '0;
    end else if (cnt_q == ($clog2(FILT_LEN+1))'(FILT_LEN - 1)) begin
      cnt_q <= '0;
      state_q <= sample_i;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule // mist_filter

/* File: hw/mist_top.sv */
// monitored 32-point input: filtering, periodic self-test, fault flags
// assumes force pins drive a test path behind the field isolation
`timescale 1ns/100ps
`include "mist_params.svh"
// Operation
// - thirty-two independent inputs, high level means active
// - state words report active as one, inactive as zero
// - self-test forces all inputs low, then high, checks each
// - self-test repeats once per second
// - whole self-test pass completes under one millisecond
// - forcing never drives or loads the field sources
// - failed channel reports fault and flashes active indicator
// - every input digitally filtered against short disturbances
// - four words exchanged: two state, two fault
// - fault bit one means faulty, zero means healthy
// - fault bit position matches the input's state bit
// - field power loss sets every fault flag
// - power return plus passing test clears fault flags
module mist_top
  import mist_pkg::*;
#(
  parameter int TEST_CYCLES = `MIST_TEST_CYCLES
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [`MIST_NPTS-1:0] field_i,
  input wire logic field_pwr_ok_i,
  output logic force_low_o,
  output logic force_high_o,
  output logic [`MIST_WORD_W-1:0] state_lo_o,
  output logic [`MIST_WORD_W-1:0] state_hi_o,
  output logic [`MIST_WORD_W-1:0] fault_lo_o,
  output logic [`MIST_WORD_W-1:0] fault_hi_o,
  output logic active_led_o,
  output logic test_busy_o
);
  localparam int NP = `MIST_NPTS;
  localparam int SETTLE = `MIST_SETTLE_CYCLES;
  localparam int BLINK = `MIST_BLINK_CYCLES;

  logic [NP-1:0] in_m_q, in_s_q;
  logic pwr_m_q, pwr_s_q;
  logic [NP-1:0] filt_st;
  logic [NP-1:0] fail_q;
  logic [NP-1:0] fault_q;
  logic [NP-1:0] state_q;
  logic pwr_lost_q;
  mist_state_t st_q;
  logic [$clog2(TEST_CYCLES)-1:0] per_q;
  logic [$clog2(SETTLE+1)-1:0] set_q;
  logic [$clog2(BLINK)-1:0] blink_q;
  logic blink_ph_q;
  logic testing;
  logic settled;

  // two-flop synchronisers on field pins
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      in_m_q <= '0;
      in_s_q <= '0;
      // power assumed present until synchronised: no false flags at reset
      pwr_m_q <= 1'b1;
      pwr_s_q <= 1'b1;
    end else begin
      in_m_q <= field_i;
      in_s_q <= in_m_q;
      pwr_m_q <= field_pwr_ok_i;
      pwr_s_q <= pwr_m_q;
    end
  end

  assign testing = (st_q != MIST_IDLE);
  assign settled = (set_q == ($clog2(SETTLE+1))'(SETTLE - 1));

  generate
    for (genvar g = 0; g < NP; g++) begin : g_ch
      mist_filter u_mist_filter (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .sample_i(in_s_q[g]),
        .hold_i(testing),
        .state_o(filt_st[g])
      );
    end
  endgenerate

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      per_q <= '0;
    end else if (per_q == ($clog2(TEST_CYCLES))'(TEST_CYCLES - 1)) begin
      per_q <= '0;
    end else begin
      per_q <= per_q + 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st_q <= MIST_IDLE;
    end else begin
      unique case (st_q)
        MIST_IDLE: begin
          if (per_q == ($clog2(TEST_CYCLES))'(TEST_CYCLES - 1)) begin
            st_q <= MIST_FLOW;
          end
        end
        MIST_FLOW: if (settled) st_q <= MIST_CHKLOW;
        MIST_CHKLOW: st_q <= MIST_FHIGH;
        MIST_FHIGH: if (settled) st_q <= MIST_CHKHIGH;
        MIST_CHKHIGH: st_q <= MIST_DONE;
        MIST_DONE: st_q <= MIST_IDLE;
      endcase
    end
  end

  // settle counter per forced phase
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      set_q <= '0;
    end else if ((st_q == MIST_FLOW || st_q == MIST_FHIGH) && !settled) begin
      set_q <= set_q + 1'b1;
    end else begin
      set_q <= '0;
    end
  end

  // force lines only steer the internal test path
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      force_low_o <= 1'b0;
      force_high_o <= 1'b0;
    end else begin
      force_low_o <= (st_q == MIST_IDLE && per_q ==
        ($clog2(TEST_CYCLES))'(TEST_CYCLES - 1)) ||
        (st_q == MIST_FLOW && !settled);
      force_high_o <= (st_q == MIST_CHKLOW) ||
        (st_q == MIST_FHIGH && !settled);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      fail_q <= '0;
    end else if (st_q == MIST_IDLE) begin
      fail_q <= '0;
    end else if (st_q == MIST_CHKLOW) begin
      fail_q <= fail_q | in_s_q;
    end else if (st_q == MIST_CHKHIGH) begin
      fail_q <= fail_q | ~in_s_q;
    end
  end

  // power loss seen since idle; a pass it overlaps cannot clear flags
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pwr_lost_q <= 1'b0;
    end else if (!pwr_s_q) begin
      pwr_lost_q <= 1'b1;
    end else if (st_q == MIST_IDLE) begin
      pwr_lost_q <= 1'b0;
    end
  end

  // cleared by passing test after power return
  // fault flags latch at pass end
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      fault_q <= '0;
    end else if (!pwr_s_q) begin
      fault_q <= '1;
    end else if (st_q == MIST_DONE) begin
      fault_q <= fail_q | {NP{pwr_lost_q}};
    end
  end

  // forced samples never reach reported state
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_q <= '0;
    end else begin
      state_q <= filt_st;
    end
  end

  assign state_lo_o = state_q[`MIST_WORD_W-1:0];
  assign state_hi_o = state_q[NP-1:`MIST_WORD_W];
  // fault words at matching bit positions
  assign fault_lo_o = fault_q[`MIST_WORD_W-1:0];
  assign fault_hi_o = fault_q[NP-1:`MIST_WORD_W];

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      blink_q <= '0;
      blink_ph_q <= 1'b0;
    end else if (blink_q == ($clog2(BLINK))'(BLINK - 1)) begin
      blink_q <= '0;
      blink_ph_q <= ~blink_ph_q;
    end else begin
      blink_q <= blink_q + 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      active_led_o <= 1'b0;
    end else begin
      active_led_o <= (|fault_q) ? blink_ph_q : 1'b1;
    end
  end

  assign test_busy_o = testing;

  // pass length well under one millisecond
  logic [15:0] pass_len_q;
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || st_q == MIST_IDLE) begin
      pass_len_q <= '0;
    end else begin
      pass_len_q <= pass_len_q + 16'h0001;
    end
  end

  chk_pass_len: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    pass_len_q < 16'h61A8)
    else $error("self-test pass too long");
  // low phase precedes high
  // force_low_o drops one edge before force_high_o rises
  chk_force_order: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    $rose(force_high_o) |-> $past(force_low_o, 2))
    else $error("high forced before low");
  chk_force_excl: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    !(force_low_o && force_high_o))
    else $error("both force lines active");
  chk_pwr_fault: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    !pwr_s_q |=> fault_q == '1)
    else $error("flags not set on power loss");
  chk_pwr_latch: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    !pwr_s_q |=> pwr_lost_q)
    else $error("power loss not latched");
  chk_fault_hold: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    (st_q != MIST_DONE && pwr_s_q) |=> $stable(fault_q))
    else $error("fault flags moved between passes");
  chk_fault_update: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    (st_q == MIST_DONE && pwr_s_q) |=>
    fault_q == ($past(fail_q) | {NP{$past(pwr_lost_q)}}))
    else $error("fault flags not latched");
  chk_pwr_clear: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    (st_q == MIST_DONE && pwr_s_q && !pwr_lost_q && fail_q == '0) |=>
    fault_q == '0)
    else $error("flags not cleared after pass");
  chk_led_steady: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    (fault_q == '0) [*2] |-> active_led_o)
    else $error("indicator not steady without fault");
  chk_led_blink: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    (|fault_q) |=> active_led_o == $past(blink_ph_q))
    else $error("indicator not blinking on fault");
  chk_state_hold: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    (testing && $past(testing, 2)) |-> $stable(state_q))
    else $error("forced samples reached state");
endmodule // mist_top

/* File: shared/mist_params.svh */
// constants for the monitored input self-test block
// assumes a 25 MHz core clock
`ifndef MIST_PARAMS_SVH
`define MIST_PARAMS_SVH
`define MIST_NPTS 32
`define MIST_WORD_W 16
`define MIST_CLK_HZ 25000000
`define MIST_TEST_PERIOD_MS 1000
`define MIST_TEST_CYCLES (`MIST_CLK_HZ / 1000 * `MIST_TEST_PERIOD_MS)
`define MIST_TEST_MAX_US 1000
`define MIST_SETTLE_US 100
`define MIST_SETTLE_CYCLES (`MIST_CLK_HZ / 1000000 * `MIST_SETTLE_US)
`define MIST_FILT_LEN 16
`define MIST_BLINK_CYCLES 6250000
`endif

/* File: shared/mist_pkg.sv */
// types for the monitored input self-test block
// used by the top module only; the filter does not import it
package mist_pkg;
  typedef enum logic [2:0] {
    MIST_IDLE,
    MIST_FLOW,
    MIST_CHKLOW,
    MIST_FHIGH,
    MIST_CHKHIGH,
    MIST_DONE
  } mist_state_t;
endpackage

/* File: tb/mist_field_model.sv */
// field side model: test path that follows the force lines
// stuck_i marks channels whose test path ignores forcing
`timescale 1ns/100ps
`include "mist_params.svh"
module mist_field_model (
  input wire logic force_low_i,
  input wire logic force_high_i,
  input wire logic [`MIST_NPTS-1:0] drive_i,
  input wire logic [`MIST_NPTS-1:0] stuck_i,
  output logic [`MIST_NPTS-1:0] field_o
);
  logic [`MIST_NPTS-1:0] forced;
  always_comb begin
    forced = force_high_i ? {`MIST_NPTS{1'b1}} : '0;
    if (force_low_i || force_high_i) begin
      field_o = (forced & ~stuck_i) | (drive_i & stuck_i);
    end else begin
      field_o = drive_i;
    end
  end
endmodule // mist_field_model

/* File: tb/monitored_input_self_test_bench.sv */
// self-checking bench for mist_top with a shortened test period
// assumes the field model stands in for the isolated test path
`timescale 1ns/100ps
`include "mist_params.svh"
module monitored_input_self_test_bench;
  localparam int TC = 8000;
  localparam int NP = `MIST_NPTS;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic pwr = 1'b1;
  logic [NP-1:0] drive = '0;
  logic [NP-1:0] stuck = '0;
  logic [NP-1:0] field;
  logic f_lo, f_hi, busy, led;
  logic [15:0] s_lo, s_hi, x_lo, x_hi;
  logic [NP:0] e;
  logic [NP:0] exp_q[$];
  int fails = 0;
  int num_checks = 0;
  int cnt = 0;
  int last_rise = 0;
  int per = 0;
  event look;
  initial forever #20 mclk_i = ~mclk_i;
  mist_field_model u_mist_field_model (.force_low_i(f_lo),
    .force_high_i(f_hi), .drive_i(drive), .stuck_i(stuck), .field_o(field));
  mist_top #(.TEST_CYCLES(TC)) u_mist_top (.mclk_i(mclk_i),
    .rst_n_i(rst_n_i), .field_i(field), .field_pwr_ok_i(pwr),
    .force_low_o(f_lo), .force_high_o(f_hi), .state_lo_o(s_lo),
    .state_hi_o(s_hi), .fault_lo_o(x_lo), .fault_hi_o(x_hi),
    .active_led_o(led), .test_busy_o(busy));
  always @(posedge mclk_i) cnt <= cnt + 1;
  always @(posedge busy) begin
    per = cnt - last_rise;
    last_rise = cnt;
  end
  task automatic results;
    if (fails == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic cmp_word(input logic [NP-1:0] got, input logic [NP-1:0] ex);
    num_checks++;
    if (got !== ex) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, ex);
    end
  endtask
  task automatic cmp_cnt(input int got, input int ex);
    num_checks++;
    if (got != ex) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, ex);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic ex);
    num_checks++;
    if (got !== ex) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, ex);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  // fault words when k is set, else state words
  task automatic note(input logic k, input logic [NP-1:0] v);
    exp_q.push_back({k, v});
    ->look;
    cyc(1);
  endtask
  task automatic wait_busy(input logic lvl, output int n);
    n = 0;
    while (busy !== lvl && n < 30000) begin
      cyc(1);
      n++;
    end
    // a wait that runs out counts as a mismatch
    if (busy !== lvl) fails++;
  endtask
  initial forever begin
    @(look);
    e = exp_q.pop_front();
    if (e[NP]) begin
      cmp_word({x_hi, x_lo}, e[NP-1:0]);
      // blink half-period outlasts the run: faulty means dark phase
      cmp_bit(led, e[NP-1:0] == '0);
    end else begin
      cmp_word({s_hi, s_lo}, e[NP-1:0]);
    end
  end
  initial begin
    #(40 * 60000);
    fails++;
    results;
  end
  initial begin
    int n;
    logic [NP-1:0] v;
    void'($urandom(32'h3744));
    cyc(2);
    rst_n_i = 1'b1;
    v = $urandom();
    drive = v;
    cyc(30);
    note(1'b0, v);
    // short glitch must not reach the state words
    drive = ~v;
    cyc(5);
    drive = v;
    cyc(30);
    note(1'b0, v);
    wait_busy(1'b1, n);
    wait_busy(1'b0, n);
    cmp_cnt(int'(n < 25000), 1);
    cyc(3);
    note(1'b1, '0);
    note(1'b0, v);
    v[20] = 1'b1;
    drive = v;
    stuck = 32'h0010_0000;
    cyc(30);
    note(1'b1, '0);
    wait_busy(1'b1, n);
    cmp_cnt(per, TC);
    wait_busy(1'b0, n);
    cyc(3);
    note(1'b1, 32'h0010_0000);
    note(1'b0, v);
    pwr = 1'b0;
    cyc(5);
    note(1'b1, '1);
    pwr = 1'b1;
    stuck = '0;
    wait_busy(1'b1, n);
    wait_busy(1'b0, n);
    cyc(3);
    note(1'b1, '0);
    results;
  end
endmodule // monitored_input_self_test_bench
